// *** include/quad_timer_pkg.sv ***
// constants for the four-timer unit
package quad_timer_pkg;
	localparam int unsigned CLK_HZ      = 20000000;
	localparam int unsigned CLK_DIV     = 16;
	localparam logic [3:0]  DIV_LAST    = 4'hF;
	localparam logic [7:0]  RST_LATCH   = 8'hFF;
	localparam logic [7:0]  RST_T1      = 8'h01;
	localparam logic [7:0]  COUNT_ZERO  = 8'h00;
	typedef enum logic [1:0] {
		MODE_TIMER  = 2'b00,
		MODE_PULSE  = 2'b01,
		MODE_EVENT  = 2'b11,
		MODE_WIDTH  = 2'b10
	} xy_mode_t;
	localparam logic [3:0] PRIO_TX   = 4'h6;
	localparam logic [3:0] PRIO_TY   = 4'h7;
	localparam logic [3:0] PRIO_T1   = 4'h8;
	localparam logic [3:0] PRIO_T2   = 4'h9;
	localparam logic [3:0] PRIO_CX   = 4'hA;
	localparam logic [3:0] PRIO_CY   = 4'hB;
	localparam logic [15:0] VEC_TX   = 16'hFFF2;
	localparam logic [15:0] VEC_TY   = 16'hFFF0;
	localparam logic [15:0] VEC_T1   = 16'hFFEE;
	localparam logic [15:0] VEC_T2   = 16'hFFEC;
	localparam logic [15:0] VEC_CX   = 16'hFFEA;
	localparam logic [15:0] VEC_CY   = 16'hFFE8;
	localparam int unsigned NREQ     = 6;
endpackage

// *** logic/down_counter.sv ***
// reloading down counter that divides its count pulses by n+1
`timescale 1ns/10ps
module down_counter #(
	parameter int unsigned W = 8,
	parameter logic [W-1:0] RST_VAL = '1
) (
	input  wire logic         clk_i,     // system clock
	input  wire logic         sys_rst_i, // async reset, high
	input  wire logic         tick_i,    // count pulse
	input  wire logic         load_i,    // latch write strobe
	input  wire logic [W-1:0] data_i,    // latch write value
	output logic [W-1:0]      count_o,   // current count
	output logic              under_o    // underflow pulse
);
	logic [W-1:0] latch_q;
	logic [W-1:0] count_q;
	logic         under_q;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			latch_q <= RST_VAL;
		end else if (load_i) begin
			latch_q <= data_i;
		end
	end

	// a write loads counter and latch together, as a fresh start
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			count_q <= RST_VAL;
			under_q <= 1'b0;
		end else begin
			under_q <= 1'b0;
			if (load_i) begin
				count_q <= data_i;
			end else if (tick_i) begin
				if (count_q == '0) begin
					count_q <= latch_q;
					under_q <= 1'b1;
				end else begin
					count_q <= count_q - 1'b1;
				end
			end
		end
	end

	assign count_o = count_q;
	assign under_o = under_q;

	property p_reload;
		@(posedge clk_i) disable iff (sys_rst_i)
		(tick_i && !load_i && count_q == '0) |=> (under_q && count_q == $past(latch_q));
	endproperty
	a_reload: assert property (p_reload) else $error("no reload on underflow");

	property p_hold;
		@(posedge clk_i) disable iff (sys_rst_i)
		(!tick_i && !load_i) |=> (count_q == $past(count_q) && !under_q);
	endproperty
	a_hold: assert property (p_hold) else $error("count moved without pulse");
endmodule

// *** logic/edge_detect.sv ***
// registered edge detector on an already synchronous input
`timescale 1ns/10ps
module edge_detect (
	input  wire logic clk_i,     // system clock
	input  wire logic sys_rst_i, // async reset, high
	input  wire logic level_i,   // sampled level
	input  wire logic fall_i,    // 1 selects falling edge
	output logic      hit_o,     // selected edge pulse
	output logic      level_o    // delayed level
);
	logic prev_q;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= level_i;
		end
	end

	assign level_o = prev_q;
	assign hit_o   = fall_i ? (prev_q & ~level_i) : (~prev_q & level_i);
endmodule

// *** logic/quad_timer_unit.sv ***
// four down timers: X, Y with modes and pins, 1 and 2 on a shared prescaler
`timescale 1ns/10ps
module quad_timer_unit #(
	parameter int unsigned W = 8
) (
	input  wire logic         clk_i,          // oscillator_input clock, 20 MHz
	input  wire logic         sys_rst_i,      // async reset, high
	input  wire logic [W-1:0] wr_data_i,      // write data for any latch
	input  wire logic         pre12_wr_i,     // write prescaler 12 latch
	input  wire logic         t1_wr_i,        // write timer 1 latch
	input  wire logic         t2_wr_i,        // write timer 2 latch
	input  wire logic         prex_wr_i,      // write prescaler X latch
	input  wire logic         tx_wr_i,        // write timer X latch
	input  wire logic         prey_wr_i,      // write prescaler Y latch
	input  wire logic         ty_wr_i,        // write timer Y latch
	input  wire logic [1:0]   x_mode_i,       // timer X mode
	input  wire logic [1:0]   y_mode_i,       // timer Y mode
	input  wire logic         x_edge_i,       // timer X edge switch bit
	input  wire logic         y_edge_i,       // timer Y edge switch bit
	input  wire logic         x_stop_i,       // timer X count stop bit
	input  wire logic         y_stop_i,       // timer Y count stop bit
	input  wire logic         timer_x_pin_i,  // timer X counter pin level
	input  wire logic         timer_y_pin_i,  // timer Y counter pin level
	input  wire logic [5:0]   req_clr_i,      // clear request bits: X,Y,1,2,cx,cy
	input  wire logic [5:0]   req_en_i,       // interrupt enable bits
	input  wire logic         irq_disable_i,  // processor interrupt disable flag
	input  wire logic         stop_instruction_i, // stop state entered
	output logic [W-1:0]      tx_count_o,     // timer X count
	output logic [W-1:0]      ty_count_o,     // timer Y count
	output logic [W-1:0]      t1_count_o,     // timer 1 count
	output logic [W-1:0]      t2_count_o,     // timer 2 count
	output logic              timer_x_pin_o,  // timer X pin drive level
	output logic              timer_x_pin_oe_n_o, // timer X pin enable, low drives
	output logic              timer_y_pin_o,  // timer Y pin drive level
	output logic              timer_y_pin_oe_n_o, // timer Y pin enable, low drives
	output logic [5:0]        req_o,          // interrupt request bits
	output logic              irq_o,          // an interrupt is taken
	output logic [3:0]        irq_prio_o,     // priority of taken source
	output logic [15:0]       irq_vec_o,      // low vector byte address
	output logic              stopped_o       // in stop state
);
	localparam int unsigned RX = 0;
	localparam int unsigned RY = 1;
	localparam int unsigned R1 = 2;
	localparam int unsigned R2 = 3;
	localparam int unsigned RCX = 4;
	localparam int unsigned RCY = 5;

	// shared divide by 16 of the oscillator clock
	logic [3:0] div_q;
	logic       div_tick_q;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			div_q      <= '0;
			div_tick_q <= 1'b0;
		end else begin
			div_q      <= div_q + 4'h1;
			div_tick_q <= (div_q == quad_timer_pkg::DIV_LAST);
		end
	end

	// counter pin sampling and edges
	logic x_hit, x_lvl, y_hit, y_lvl;
	edge_detect u_x_edge (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.level_i   (timer_x_pin_i),
		.fall_i    (x_edge_i),
		.hit_o     (x_hit),
		.level_o   (x_lvl)
	);
	edge_detect u_y_edge (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.level_i   (timer_y_pin_i),
		.fall_i    (y_edge_i),
		.hit_o     (y_hit),
		.level_o   (y_lvl)
	);
	// prescaler 12, timer 1, timer 2
	logic [W-1:0] pre12_cnt, t1_cnt, t2_cnt;
	logic         pre12_uf, t1_uf, t2_uf;

	down_counter #(.W(W), .RST_VAL(W'(quad_timer_pkg::RST_LATCH))) u_pre12 (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.tick_i    (div_tick_q),
		.load_i    (pre12_wr_i),
		.data_i    (wr_data_i),
		.count_o   (pre12_cnt),
		.under_o   (pre12_uf)
	);
	down_counter #(.W(W), .RST_VAL(W'(quad_timer_pkg::RST_T1))) u_t1 (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.tick_i    (pre12_uf),
		.load_i    (t1_wr_i),
		.data_i    (wr_data_i),
		.count_o   (t1_cnt),
		.under_o   (t1_uf)
	);
	down_counter #(.W(W), .RST_VAL(W'(quad_timer_pkg::RST_LATCH))) u_t2 (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.tick_i    (pre12_uf),
		.load_i    (t2_wr_i),
		.data_i    (wr_data_i),
		.count_o   (t2_cnt),
		.under_o   (t2_uf)
	);

	// count sources for X and Y by mode
	function automatic logic xy_src(input logic [1:0] mode, input logic stop,
		input logic div, input logic hit, input logic lvl, input logic edge_b);
		logic s;
		s = 1'b0;
		case (mode)
			quad_timer_pkg::MODE_TIMER: s = div;
			quad_timer_pkg::MODE_PULSE: s = div;
			quad_timer_pkg::MODE_EVENT: s = hit;
			quad_timer_pkg::MODE_WIDTH: s = div & (lvl ^ edge_b);
			default:                    s = 1'b0;
		endcase
		return s & ~stop;
	endfunction

	logic x_src, y_src;
	assign x_src = xy_src(x_mode_i, x_stop_i, div_tick_q, x_hit, x_lvl, x_edge_i);
	assign y_src = xy_src(y_mode_i, y_stop_i, div_tick_q, y_hit, y_lvl, y_edge_i);

	logic [W-1:0] prex_cnt, prey_cnt, tx_cnt, ty_cnt;
	logic         prex_uf, prey_uf, tx_uf, ty_uf;

	down_counter #(.W(W), .RST_VAL(W'(quad_timer_pkg::RST_LATCH))) u_prex (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.tick_i    (x_src),
		.load_i    (prex_wr_i),
		.data_i    (wr_data_i),
		.count_o   (prex_cnt),
		.under_o   (prex_uf)
	);

	// a stop set in the prescaler's underflow cycle must not leak into the timer
	down_counter #(.W(W), .RST_VAL(W'(quad_timer_pkg::RST_LATCH))) u_tx (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.tick_i    (prex_uf & ~x_stop_i),
		.load_i    (tx_wr_i),
		.data_i    (wr_data_i),
		.count_o   (tx_cnt),
		.under_o   (tx_uf)
	);
	down_counter #(.W(W), .RST_VAL(W'(quad_timer_pkg::RST_LATCH))) u_prey (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.tick_i    (y_src),
		.load_i    (prey_wr_i),
		.data_i    (wr_data_i),
		.count_o   (prey_cnt),
		.under_o   (prey_uf)
	);
	down_counter #(.W(W), .RST_VAL(W'(quad_timer_pkg::RST_LATCH))) u_ty (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.tick_i    (prey_uf & ~y_stop_i),
		.load_i    (ty_wr_i),
		.data_i    (wr_data_i),
		.count_o   (ty_cnt),
		.under_o   (ty_uf)
	);

	// registered count outputs
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tx_count_o <= W'(quad_timer_pkg::RST_LATCH);
			ty_count_o <= W'(quad_timer_pkg::RST_LATCH);
			t1_count_o <= W'(quad_timer_pkg::RST_T1);
			t2_count_o <= W'(quad_timer_pkg::RST_LATCH);
		end else begin
			tx_count_o <= tx_cnt;
			ty_count_o <= ty_cnt;
			t1_count_o <= t1_cnt;
			t2_count_o <= t2_cnt;
		end
	end

	// pulse output: level restarts from the inverted edge bit whenever not in pulse mode.
	// the pin enable is driven low here whenever the timer is in pulse mode, high otherwise
	logic x_pulse, y_pulse;
	assign x_pulse = (x_mode_i == quad_timer_pkg::MODE_PULSE);
	assign y_pulse = (y_mode_i == quad_timer_pkg::MODE_PULSE);

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			timer_x_pin_o      <= 1'b1;
			timer_x_pin_oe_n_o <= 1'b1;
		end else begin
			timer_x_pin_oe_n_o <= ~x_pulse;
			if (!x_pulse) begin
				timer_x_pin_o <= ~x_edge_i;
			end else if (tx_uf) begin
				timer_x_pin_o <= ~timer_x_pin_o;
			end
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			timer_y_pin_o      <= 1'b1;
			timer_y_pin_oe_n_o <= 1'b1;
		end else begin
			timer_y_pin_oe_n_o <= ~y_pulse;
			if (!y_pulse) begin
				timer_y_pin_o <= ~y_edge_i;
			end else if (ty_uf) begin
				timer_y_pin_o <= ~timer_y_pin_o;
			end
		end
	end

	// request bits: set wins over a clear in the same cycle
	logic [5:0] ev;
	assign ev[RX]  = tx_uf;
	assign ev[RY]  = ty_uf;
	assign ev[R1]  = t1_uf;
	assign ev[R2]  = t2_uf;
	assign ev[RCX] = x_hit;
	assign ev[RCY] = y_hit;

	logic [5:0] req_q;
	generate
		for (genvar i = 0; i < quad_timer_pkg::NREQ; i++) begin : g_req
			always_ff @(posedge clk_i or posedge sys_rst_i) begin
				if (sys_rst_i) begin
					req_q[i] <= 1'b0;
				end else if (ev[i]) begin
					req_q[i] <= 1'b1;
				end else if (req_clr_i[i]) begin
					req_q[i] <= 1'b0;
				end
			end
		end
	endgenerate
	assign req_o = req_q;

	// fixed priority pick, lowest number first
	logic [5:0]  pend;
	logic [3:0]  prio_d;
	logic [15:0] vec_d;
	assign pend = req_q & req_en_i & {6{~irq_disable_i}};

	always_comb begin
		prio_d = '0;
		vec_d  = '0;
		if (pend[RX]) begin
			prio_d = quad_timer_pkg::PRIO_TX;
			vec_d  = quad_timer_pkg::VEC_TX;
		end else if (pend[RY]) begin
			prio_d = quad_timer_pkg::PRIO_TY;
			vec_d  = quad_timer_pkg::VEC_TY;
		end else if (pend[R1]) begin
			prio_d = quad_timer_pkg::PRIO_T1;
			vec_d  = quad_timer_pkg::VEC_T1;
		end else if (pend[R2]) begin
			prio_d = quad_timer_pkg::PRIO_T2;
			vec_d  = quad_timer_pkg::VEC_T2;
		end else if (pend[RCX]) begin
			prio_d = quad_timer_pkg::PRIO_CX;
			vec_d  = quad_timer_pkg::VEC_CX;
		end else if (pend[RCY]) begin
			prio_d = quad_timer_pkg::PRIO_CY;
			vec_d  = quad_timer_pkg::VEC_CY;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_o      <= 1'b0;
			irq_prio_o <= '0;
			irq_vec_o  <= '0;
		end else begin
			irq_o      <= |pend;
			irq_prio_o <= prio_d;
			irq_vec_o  <= vec_d;
		end
	end

	// stop state ends on timer 1 underflow; entry wins only without underflow
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			stopped_o <= 1'b0;
		end else if (t1_uf) begin
			stopped_o <= 1'b0;
		end else if (stop_instruction_i) begin
			stopped_o <= 1'b1;
		end
	end

	property p_req_set;
		@(posedge clk_i) disable iff (sys_rst_i)
		t1_uf |=> req_o[R1];
	endproperty
	a_req_set: assert property (p_req_set) else $error("timer 1 request not set");
	property p_stop_x;
		@(posedge clk_i) disable iff (sys_rst_i)
		(x_stop_i && !tx_wr_i) [*2] |-> (tx_cnt == $past(tx_cnt));
	endproperty
	a_stop_x: assert property (p_stop_x) else $error("timer X moved while stopped");
	property p_pulse_tog;
		@(posedge clk_i) disable iff (sys_rst_i)
		(x_pulse && $past(x_pulse) && tx_uf) |=> (timer_x_pin_o != $past(timer_x_pin_o));
	endproperty
	a_pulse_tog: assert property (p_pulse_tog) else $error("pulse pin did not toggle");
	property p_pulse_start;
		@(posedge clk_i) disable iff (sys_rst_i)
		!x_pulse |=> (timer_x_pin_o == !$past(x_edge_i));
	endproperty
	a_pulse_start: assert property (p_pulse_start) else $error("pulse start level wrong");
	property p_masked;
		@(posedge clk_i) disable iff (sys_rst_i)
		irq_disable_i |=> !irq_o;
	endproperty
	a_masked: assert property (p_masked) else $error("interrupt taken while disabled");
	property p_prio_tx;
		@(posedge clk_i) disable iff (sys_rst_i)
		pend[RX] |=> (irq_prio_o == quad_timer_pkg::PRIO_TX && irq_vec_o == quad_timer_pkg::VEC_TX);
	endproperty
	a_prio_tx: assert property (p_prio_tx) else $error("timer X priority wrong");
	property p_wake;
		@(posedge clk_i) disable iff (sys_rst_i)
		t1_uf |=> !stopped_o;
	endproperty
	a_wake: assert property (p_wake) else $error("stop not released");
	property p_div;
		@(posedge clk_i) disable iff (sys_rst_i)
		div_tick_q |=> !div_tick_q [*8] ##1 !div_tick_q [*7] ##1 div_tick_q;
	endproperty
	a_div: assert property (p_div) else $error("divide by 16 broken");
endmodule

// *** tb/pin_source.sv ***
// external pulse source and load on one counter pin
`timescale 1ns/10ps
module pin_source (
	input  wire logic clk_i,   // system clock
	input  wire logic run_i,   // 1 emits a pulse train, one rising edge per 4 clocks
	input  wire logic level_i, // level held while not pulsing
	input  wire logic drv_i,   // level driven by the device
	input  wire logic oe_n_i,  // low while the device drives
	output logic      line_o   // resolved pin level
);
	logic [1:0] ph_q;
	logic       src_q;
	initial begin
		ph_q = 2'h0;
		src_q = 1'b0;
	end
	always @(posedge clk_i) begin
		ph_q <= ph_q + 2'h1;
		src_q <= run_i ? ph_q[1] : level_i;
	end
	// the source backs off while the pin is set to output
	assign line_o = oe_n_i ? src_q : drv_i;
endmodule

// *** tb/tb.sv ***
// self-checking bench for the four-timer unit
`timescale 1ns/10ps
module tb;
	logic        clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic [7:0]  wr_data_i = 8'h00;
	logic [6:0]  wr = 7'h00;
	logic [1:0]  x_mode_i = 2'b00;
	logic [1:0]  y_mode_i = 2'b00;
	logic        x_edge_i = 1'b0;
	logic        y_edge_i = 1'b0;
	logic        x_stop_i = 1'b0;
	logic        y_stop_i = 1'b0;
	logic        irq_disable_i = 1'b0;
	logic        stop_instruction_i = 1'b0;
	logic [5:0]  req_clr_i = 6'h00;
	logic [5:0]  req_en_i = 6'h00;
	logic        xrun = 1'b0;
	logic        yrun = 1'b0;
	logic        xlvl = 1'b0;
	logic        ylvl = 1'b0;
	logic        timer_x_pin_i;
	logic        timer_y_pin_i;
	logic [7:0]  tx_count_o;
	logic [7:0]  ty_count_o;
	logic [7:0]  t1_count_o;
	logic [7:0]  t2_count_o;
	logic        timer_x_pin_o;
	logic        timer_y_pin_o;
	logic        x_oe_n;
	logic        y_oe_n;
	logic [5:0]  req_o;
	logic        irq_o;
	logic [3:0]  irq_prio_o;
	logic [15:0] irq_vec_o;
	logic        stopped_o;
	logic        ref_pin;
	logic [7:0]  ref_cnt;
	integer      num_errors = 0;
	integer      tests_run = 0;
	integer      seed = 67449;
	integer      cyc = 0;

	quad_timer_unit #(.W(8)) quad_timer_unit_i (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wr_data_i(wr_data_i),
		.pre12_wr_i(wr[0]), .t1_wr_i(wr[1]), .t2_wr_i(wr[2]), .prex_wr_i(wr[3]),
		.tx_wr_i(wr[4]), .prey_wr_i(wr[5]), .ty_wr_i(wr[6]),
		.x_mode_i(x_mode_i), .y_mode_i(y_mode_i), .x_edge_i(x_edge_i), .y_edge_i(y_edge_i),
		.x_stop_i(x_stop_i), .y_stop_i(y_stop_i),
		.timer_x_pin_i(timer_x_pin_i), .timer_y_pin_i(timer_y_pin_i),
		.req_clr_i(req_clr_i), .req_en_i(req_en_i), .irq_disable_i(irq_disable_i),
		.stop_instruction_i(stop_instruction_i),
		.tx_count_o(tx_count_o), .ty_count_o(ty_count_o),
		.t1_count_o(t1_count_o), .t2_count_o(t2_count_o),
		.timer_x_pin_o(timer_x_pin_o), .timer_x_pin_oe_n_o(x_oe_n),
		.timer_y_pin_o(timer_y_pin_o), .timer_y_pin_oe_n_o(y_oe_n),
		.req_o(req_o), .irq_o(irq_o), .irq_prio_o(irq_prio_o), .irq_vec_o(irq_vec_o),
		.stopped_o(stopped_o)
	);
	pin_source pin_source_x (.clk_i(clk_i), .run_i(xrun), .level_i(xlvl),
		.drv_i(timer_x_pin_o), .oe_n_i(x_oe_n), .line_o(timer_x_pin_i));
	pin_source pin_source_y (.clk_i(clk_i), .run_i(yrun), .level_i(ylvl),
		.drv_i(timer_y_pin_o), .oe_n_i(y_oe_n), .line_o(timer_y_pin_i));

	always #25 clk_i = ~clk_i;
	always @(posedge clk_i) cyc <= cyc + 1;

	task conclude;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk_val(input string n, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task chk_int(input string n, input int e, input int g);
		tests_run++;
		if (g != e) begin
			num_errors++;
			$display("[FAIL] %s expected %0d seen %0d", n, e, g);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// strobe order: pre12, t1, t2, prex, tx, prey, ty
	task wr_latch(input int k, input logic [7:0] d);
		wr_data_i <= d;
		wr <= 7'h01 << k;
		@(posedge clk_i);
		wr <= 7'h00;
		@(posedge clk_i);
	endtask
	// 0..5 request set, 6 stop state left, 7 x pin moved, 8 x count moved
	task wait_for(input int k, input int lim);
		int i;
		for (i = 0; i < lim; i++) begin
			@(posedge clk_i);
			if ((k < 6 && req_o[k] === 1'b1) || (k == 6 && stopped_o === 1'b0) ||
			    (k == 7 && timer_x_pin_o !== ref_pin) || (k == 8 && tx_count_o !== ref_cnt))
				break;
		end
		if (i == lim) begin
			num_errors++;
			$display("[FAIL] wait %0d expected event within %0d cycles seen none", k, lim);
			conclude();
		end
	endtask
	task clr(input int k);
		req_clr_i <= 6'h01 << k;
		@(posedge clk_i);
		req_clr_i <= 6'h00;
		@(posedge clk_i);
	endtask
	task irq_chk(input int k);
		req_en_i <= 6'h01 << k;
		tick(3);
		chk_val("irq", 16'h0001, {15'h0000, irq_o});
		chk_val("prio", 16'h0006 + k, {12'h000, irq_prio_o});
		chk_val("vec", 16'hFFF2 - 2 * k, irq_vec_o);
		irq_disable_i <= 1'b1;
		tick(3);
		chk_val("irq masked", 16'h0000, {15'h0000, irq_o});
		irq_disable_i <= 1'b0;
		req_en_i <= 6'h00;
	endtask
	// clock cycles per request: div, then prescaler and timer each divide by their latch plus one
	function automatic int exp_period(input int div, input int p, input int t);
		return div * (p + 1) * (t + 1);
	endfunction
	// distance between two request sets must equal div*(p+1)*(t+1)
	task meas(input int k, input int p, input int t, input int div);
		int t0;
		// a stale bit, or a set that meets the clear, would skew t0: resync first
		clr(k);
		wait_for(k, 9000);
		clr(k);
		wait_for(k, 9000);
		t0 = cyc;
		clr(k);
		wait_for(k, 9000);
		chk_int("period", exp_period(div, p, t), cyc - t0);
		irq_chk(k);
		clr(k);
	endtask

	initial begin
		int i;
		int p;
		int t;
		int t0;
		tick(12);
		chk_val("t1 rst", 16'h0001, {8'h00, t1_count_o});
		chk_val("tx rst", 16'h00FF, {8'h00, tx_count_o});
		chk_val("req rst", 16'h0000, {10'h000, req_o});
		chk_val("t2 rst", 16'h00FF, {8'h00, t2_count_o});
		chk_val("ty rst", 16'h00FF, {8'h00, ty_count_o});
		sys_rst_i <= 1'b0;
		tick(2);
		chk_val("y idle pin", 16'h0001, {15'h0000, timer_y_pin_o});
		chk_val("y idle oe_n", 16'h0001, {15'h0000, y_oe_n});
		for (i = 0; i < 3; i++) begin
			p = (i == 0) ? 0 : ($random(seed) & 3);
			t = $random(seed) & 3;
			wr_latch(0, p[7:0]);
			wr_latch(1, t[7:0]);
			wr_latch(2, 8'h03 - t[7:0]);
			meas(2, p, t, 16);
			meas(3, p, 3 - t, 16);
		end
		for (i = 0; i < 3; i++) begin
			p = (i == 2) ? 0 : ($random(seed) & 3);
			t = (i == 2) ? 255 : ($random(seed) & 7);
			wr_latch(3, p[7:0]);
			wr_latch(4, t[7:0]);
			meas(0, p, t, 16);
		end
		x_stop_i <= 1'b1;
		tick(3);
		ref_cnt = tx_count_o;
		tick(64);
		chk_val("stop hold", {8'h00, ref_cnt}, {8'h00, tx_count_o});
		x_stop_i <= 1'b0;
		wait_for(8, 40);
		chk_val("resume", {8'h00, ref_cnt - 8'h01}, {8'h00, tx_count_o});
		// y counts pin edges while x keeps timer mode, so modes are independent
		y_mode_i <= 2'b11;
		yrun <= 1'b1;
		t = $random(seed) & 7;
		wr_latch(5, 8'h00);
		wr_latch(6, t[7:0]);
		meas(1, 0, t, 4);
		chk_val("y edge req", 16'h0001, {15'h0000, req_o[5]});
		irq_chk(5);
		yrun <= 1'b0;
		x_mode_i <= 2'b10;
		wr_latch(3, 8'h00);
		wr_latch(4, 8'h03);
		tick(64);
		chk_val("width idle", 16'h0003, {8'h00, tx_count_o});
		xlvl <= 1'b1;
		meas(0, 0, 3, 16);
		chk_val("x edge req", 16'h0001, {15'h0000, req_o[4]});
		irq_chk(4);
		for (i = 0; i < 2; i++) begin
			// latches first, so no underflow can flip the pin before it is looked at
			x_mode_i <= 2'b00;
			y_mode_i <= 2'b00;
			x_edge_i <= i[0];
			y_edge_i <= ~i[0];
			wr_latch(3, 8'h00);
			wr_latch(4, 8'h02);
			wr_latch(5, 8'h00);
			wr_latch(6, 8'h02);
			x_mode_i <= 2'b01;
			y_mode_i <= 2'b01;
			tick(2);
			chk_val("x oe_n", 16'h0000, {15'h0000, x_oe_n});
			chk_val("x start", {15'h0000, ~i[0]}, {15'h0000, timer_x_pin_o});
			chk_val("y oe_n", 16'h0000, {15'h0000, y_oe_n});
			chk_val("y start", {15'h0000, i[0]}, {15'h0000, timer_y_pin_o});
			ref_pin = timer_x_pin_o;
			wait_for(7, 200);
			t0 = cyc;
			ref_pin = timer_x_pin_o;
			wait_for(7, 200);
			chk_int("toggle", 48, cyc - t0);
		end
		wr_latch(0, 8'h00);
		wr_latch(1, 8'h03);
		clr(2);
		stop_instruction_i <= 1'b1;
		tick(1);
		stop_instruction_i <= 1'b0;
		tick(2);
		chk_val("stopped", 16'h0001, {15'h0000, stopped_o});
		wait_for(6, 200);
		tick(1);
		chk_val("wake req", 16'h0001, {15'h0000, req_o[2]});
		conclude();
	end
endmodule
